/* File: cpu_register_file_stack_wake.sv */
// CPU general registers, program counter, flags, stack transfers and wake wait
`timescale 1ns/100ps
`include "cpu_regs_consts.svh"
module cpu_register_file_stack_wake
  import cpu_regs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // Register write port
  input  wire xfer_size_t  wrSize,
  input  wire logic [2:0]  wrIdx,
  input  wire logic        wrHigh,
  input  wire logic [15:0] wrData,
  // Register read port
  input  wire logic [2:0]  rdIdx,
  input  wire logic        rdHigh,
  output logic [15:0]      rdWord,
  output logic [7:0]       rdByte,
  // Address from a pointer register
  input  wire logic [2:0]  ptrIdx,
  output logic [15:0]      ptrAddr,
  // Short absolute addressing request
  input  wire logic        shortAbsReq,
  input  wire xfer_size_t  shortAbsSize,
  output logic             shortAbsIllegal,
  // Stack transfers
  input  wire stack_op_t   stackOp,
  input  wire logic [2:0]  stackIdx,
  input  wire logic [15:0] stackRdData,
  output logic [15:0]      stackAddr,
  output logic [15:0]      stackWrData,
  output logic             stackWrEn,
  // Program counter and flags
  input  wire logic        pcLoad,
  input  wire logic [15:0] pcLoadVal,
  input  wire logic        pcStep,
  output logic [15:0]      fetchAddr,
  input  wire logic        flagsWr,
  input  wire logic [7:0]  flagsWrData,
  output logic [7:0]       conditionFlags,
  input  wire logic        firstInsnDone,
  output logic             irqMasked,
  // Halt and wake
  input  wire logic        haltReq,
  input  wire logic        wakeIrq,
  input  wire logic        oscStable,
  input  wire logic [2:0]  standbyWaitSelect,
  input  wire logic        extendedWait,
  output logic             coreRun
);
  logic [15:0] gpr_q [`REG_COUNT];
  logic [15:0] pc_q;
  logic [7:0]  flags_q;
  logic        resetMask_q;
  logic [15:0] spWord, spDec, spInc;
  logic        pushGo, popGo;

  // Byte-lane merge shared by plain writes and stack pops
  function automatic logic [15:0] mergeWrite(input logic [15:0] old, input xfer_size_t sz,
                                             input logic hi, input logic [15:0] d);
    logic [15:0] r;
    r = old;
    if (sz == XFER_WORD) r = d;
    else if (sz == XFER_BYTE && hi) r = {d[7:0], old[7:0]};
    else if (sz == XFER_BYTE) r = {old[15:8], d[7:0]};
    return r;
  endfunction : mergeWrite

  assign spWord = gpr_q[`STACK_REG_IDX];
  assign spDec  = spWord - `WORD_STEP;
  assign spInc  = spWord + `WORD_STEP;
  assign pushGo = coreRun && (stackOp == STK_PUSH);
  assign popGo  = coreRun && (stackOp == STK_POP);

  // Push puts the decremented pointer on the bus; pop reads the current top
  assign stackAddr   = pushGo ? spDec : spWord;
  assign stackWrData = gpr_q[stackIdx];
  assign stackWrEn   = pushGo;

  assign rdWord = gpr_q[rdIdx];
  assign rdByte = rdHigh ? gpr_q[rdIdx][15:8] : gpr_q[rdIdx][7:0];
  assign ptrAddr = gpr_q[ptrIdx];
  assign shortAbsIllegal = shortAbsReq && (shortAbsSize == XFER_WORD);

  genvar g;
  generate
    for (g = 0; g < `REG_COUNT; g++) begin : gRegs
      logic [15:0] next;
      always_comb begin
        next = gpr_q[g];
        if (coreRun && !(shortAbsIllegal && wrIdx == `REG_IDX_W'(g)) && wrIdx == `REG_IDX_W'(g))
          next = mergeWrite(gpr_q[g], wrSize, wrHigh, wrData);
        if (g == `STACK_REG_IDX && pushGo) next = spDec;
        if (g == `STACK_REG_IDX && popGo) next = spInc;
        // Popping into the pointer itself keeps the loaded word, as a word transfer would
        if (popGo && stackIdx == `REG_IDX_W'(g))
          next = mergeWrite(gpr_q[g], XFER_WORD, 1'b0, stackRdData);
      end
      always_ff @(posedge clk) begin
        if (rst) gpr_q[g] <= (g == `STACK_REG_IDX) ? `SP_RESET : 16'h0000;
        else if (clkEn) gpr_q[g] <= next;
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      pc_q        <= `PC_RESET;
      flags_q     <= `FLAGS_RESET;
      resetMask_q <= 1'b1;
    end else if (clkEn) begin
      if (pcLoad) pc_q <= {pcLoadVal[15:1], 1'b0};
      else if (pcStep && coreRun) pc_q <= pc_q + `WORD_STEP;
      if (flagsWr && coreRun) flags_q <= flagsWrData;
      if (firstInsnDone && coreRun) resetMask_q <= 1'b0;
    end
  end

  assign fetchAddr      = {pc_q[15:1], 1'b0};
  assign conditionFlags = flags_q;
  assign irqMasked      = resetMask_q || flags_q[`FLAGS_IMASK_BIT];

  wake_wait_timer uWake (
    .clk               (clk),
    .rst               (rst),
    .clkEn             (clkEn),
    .haltReq           (haltReq),
    .wakeIrq           (wakeIrq),
    .oscStable         (oscStable),
    .standbyWaitSelect (standbyWaitSelect),
    .extendedWait      (extendedWait),
    .coreRun           (coreRun)
  );
endmodule : cpu_register_file_stack_wake

/* File: cpu_register_file_stack_wake_tb_top.sv */
// Self-checking testbench for the CPU register file, stack and wake block
`timescale 1ns/100ps
module cpu_register_file_stack_wake_tb_top
  import cpu_regs_pkg::*;
;
  logic        clk, rst, clkEn, wrHigh, rdHigh, shortAbsReq, pcLoad, pcStep, flagsWr, firstInsnDone;
  logic        haltReq, wakeIrq, oscStable, extendedWait, shortAbsIllegal, stackWrEn, irqMasked, coreRun;
  logic [2:0]  wrIdx, rdIdx, ptrIdx, stackIdx, standbyWaitSelect;
  logic [7:0]  rdByte, flagsWrData, conditionFlags;
  logic [15:0] wrData, stackRdData, pcLoadVal, rdWord, ptrAddr, stackAddr, stackWrData, fetchAddr;
  xfer_size_t  wrSize, shortAbsSize;
  stack_op_t   stackOp;
  int          failCount, numChecks;

  cpu_register_file_stack_wake dut_u (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #5;
  endtask : step

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input xfer_size_t s, input logic [2:0] i, input logic h, input logic [15:0] d);
    wrSize = s;
    wrIdx  = i;
    wrHigh = h;
    wrData = d;
    step();
    wrSize = XFER_NONE;
  endtask : wr

  task automatic t_regs;
    for (int i = 0; i < 8; i++) wr(XFER_WORD, 3'(i), 1'b0, 16'(16'h1111 * i));
    for (int i = 0; i < 8; i++) begin
      rdIdx  = 3'(i);
      ptrIdx = 3'(i);
      #1;
      chk("rdWord", rdWord, 16'(16'h1111 * i));
      chk("ptrAddr", ptrAddr, 16'(16'h1111 * i));
    end
    wr(XFER_BYTE, 3'h3, 1'b1, 16'h00AB);
    wr(XFER_BYTE, 3'h3, 1'b0, 16'h00CD);
    rdIdx  = 3'h3;
    rdHigh = 1'b1;
    #1;
    chk("byte halves", rdWord, 16'hABCD);
    chk("rdByte", 16'(rdByte), 16'h00AB);
    shortAbsReq = 1'b1;
    shortAbsSize = XFER_BYTE;
    #1;
    chk("short byte", 16'(shortAbsIllegal), 16'h0000);
    shortAbsSize = XFER_WORD;
    #1;
    chk("short word", 16'(shortAbsIllegal), 16'h0001);
    wr(XFER_WORD, 3'h3, 1'b0, 16'hFFFF);
    shortAbsReq = 1'b0;
    chk("blocked write", rdWord, 16'hABCD);
  endtask : t_regs

  task automatic t_pc_flags;
    pcLoad = 1'b1;
    pcLoadVal = 16'h1235;
    step();
    pcLoad = 1'b0;
    chk("fetchAddr", fetchAddr, 16'h1234);
    pcStep = 1'b1;
    flagsWr = 1'b1;
    flagsWrData = 8'h05;
    step();
    {pcStep, flagsWr} = 2'b00;
    chk("pc step", fetchAddr, 16'h1236);
    chk("flags", 16'(conditionFlags), 16'h0005);
    chk("still masked", 16'(irqMasked), 16'h0001);
    firstInsnDone = 1'b1;
    step();
    firstInsnDone = 1'b0;
    chk("unmasked", 16'(irqMasked), 16'h0000);
  endtask : t_pc_flags

  task automatic t_stack;
    wr(XFER_WORD, 3'h7, 1'b0, 16'h0100);
    stackOp = STK_PUSH;
    stackIdx = 3'h3;
    #1;
    chk("push addr", stackAddr, 16'h00FE);
    chk("push strobe", 16'(stackWrEn), 16'h0001);
    chk("push data", stackWrData, 16'hABCD);
    step();
    stackOp = STK_NONE;
    #1;
    chk("sp after push", stackAddr, 16'h00FE);
    stackOp = STK_POP;
    stackIdx = 3'h2;
    stackRdData = 16'h5A5A;
    step();
    stackOp = STK_NONE;
    stackRdData = 16'hA5A5;
    rdIdx = 3'h2;
    #1;
    chk("sp after pop", stackAddr, 16'h0100);
    chk("pop data", rdWord, 16'h5A5A);
  endtask : t_stack

  task automatic t_wake(input logic [2:0] c, input int n);
    int k;
    k = 0;
    standbyWaitSelect = c;
    haltReq = 1'b1;
    step();
    haltReq = 1'b0;
    step();
    chk("halted", 16'(coreRun), 16'h0000);
    wakeIrq = 1'b1;
    step();
    wakeIrq = 1'b0;
    oscStable = 1'b1;
    while (coreRun !== 1'b1 && k < 40000) begin
      step();
      k++;
    end
    oscStable = 1'b0;
    chk("wake wait", 16'(k >= n && k <= n + 3), 16'h0001);
  endtask : t_wake

  task automatic summarize;
    $display("Checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  initial begin
    {clkEn, rst} = 2'b11;
    {wrHigh, rdHigh, shortAbsReq, pcLoad, pcStep, flagsWr, firstInsnDone, haltReq, wakeIrq} = '0;
    {oscStable, extendedWait, wrIdx, rdIdx, ptrIdx, stackIdx, standbyWaitSelect} = '0;
    {wrData, stackRdData, pcLoadVal, flagsWrData} = '0;
    {wrSize, shortAbsSize, stackOp} = {XFER_NONE, XFER_NONE, STK_NONE};
    step(12);
    rst = 1'b0;
    chk("reset mask", 16'(irqMasked), 16'h0001);
    chk("reset pc", fetchAddr, 16'h0000);
    t_regs();
    t_pc_flags();
    t_stack();
    t_wake(3'h6, 8);
    t_wake(3'h5, 8);
    t_wake(3'h7, 16);
    t_wake(3'h2, 1024);
    // Long table only reachable with the strap set; longest code kept off to bound run time
    extendedWait = 1'b1;
    t_wake(3'h2, 32768);
    extendedWait = 1'b0;
    summarize();
  end

  initial begin
    #6000000;
    failCount++;
    summarize();
  end
endmodule : cpu_register_file_stack_wake_tb_top

/* File: cpu_regs_consts.svh */
// Constants for the CPU register file, stack and wake logic
`ifndef CPU_REGS_CONSTS_SVH
`define CPU_REGS_CONSTS_SVH
`define REG_COUNT        8
`define REG_IDX_W        3
`define STACK_REG_IDX    3'h7
`define WORD_STEP        16'h0002
`define PC_RESET         16'h0000
`define SP_RESET         16'h0000
`define FLAGS_RESET      8'h00
`define FLAGS_IMASK_BIT  7
`define WAIT_SEL_RESET   3'h0
`define WAIT_CNT_W       18
`define WAIT_MIN_STATES  18'h00008
`define WAIT_SEL_0       18'h02000
`define WAIT_SEL_1       18'h04000
`define WAIT_SEL_2       18'h00400
`define WAIT_SEL_3       18'h00800
`define WAIT_SEL_4       18'h01000
`define WAIT_SEL_5       18'h00002
`define WAIT_SEL_6       18'h00008
`define WAIT_SEL_7       18'h00010
`define WAIT_EXT_2       18'h08000
`define WAIT_EXT_3       18'h10000
`define WAIT_EXT_4       18'h20000
`endif

/* File: cpu_regs_pkg.sv */
// Types for the CPU register file block
package cpu_regs_pkg;
  typedef enum logic [1:0] {
    XFER_NONE = 2'b00,
    XFER_BYTE = 2'b01,
    XFER_WORD = 2'b10
  } xfer_size_t;
  typedef enum logic [1:0] {
    STK_NONE = 2'b00,
    STK_PUSH = 2'b01,
    STK_POP  = 2'b10
  } stack_op_t;
  typedef enum logic [1:0] {
    WK_RUN    = 2'b00,
    WK_HALT   = 2'b01,
    WK_SETTLE = 2'b10,
    WK_WAIT   = 2'b11
  } wake_state_t;
endpackage : cpu_regs_pkg

/* File: cpu_rf_asserts.sv */
// Port checks for the CPU register file, stack and wake block
`timescale 1ns/100ps
module cpu_rf_asserts
  import cpu_regs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        clkEn,
  input wire xfer_size_t  wrSize,
  input wire stack_op_t   stackOp,
  input wire logic [2:0]  stackIdx,
  input wire logic [15:0] stackAddr,
  input wire logic        stackWrEn,
  input wire logic        pcLoad,
  input wire logic [15:0] pcLoadVal,
  input wire logic        pcStep,
  input wire logic [15:0] fetchAddr,
  input wire logic        irqMasked,
  input wire logic        coreRun,
  input wire logic        haltReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_fetch_word_even: assert property (fetchAddr[0] == 1'b0) else $error("odd fetch address");
  a_pc_load_taken: assert property (pcLoad && clkEn && !pcStep |=> fetchAddr == ($past(pcLoadVal) & 16'hFFFE))
    else $error("pc load lost");
  a_pc_step_two: assert property (pcStep && !pcLoad && coreRun && clkEn |=> fetchAddr == $past(fetchAddr) + 16'h0002)
    else $error("pc step wrong");
  a_push_strobe: assert property (stackOp == STK_PUSH && coreRun && clkEn |-> stackWrEn) else $error("no push write");
  a_push_then_sp: assert property (stackOp == STK_PUSH && coreRun && clkEn ##1 stackOp == STK_NONE
    && $past(wrSize) == XFER_NONE |-> stackAddr == $past(stackAddr)) else $error("push pointer wrong");
  a_pop_then_sp: assert property (stackOp == STK_POP && stackIdx != 3'h7 && coreRun && clkEn ##1 stackOp == STK_NONE
    && $past(wrSize) == XFER_NONE |-> stackAddr == $past(stackAddr) + 16'h0002) else $error("pop pointer wrong");
  a_reset_masks_irq: assert property (disable iff (1'b0) rst |=> irqMasked && coreRun)
    else $error("reset state wrong");
  a_halt_stops_core: assert property (haltReq && coreRun && clkEn |=> !coreRun) else $error("halt ignored");
  a_wake_min_wait: assert property ($rose(coreRun) && !$past(rst) |-> !$past(coreRun, 8))
    else $error("wake wait too short");
  c_push: cover property (stackOp == STK_PUSH && coreRun);
  c_pop: cover property (stackOp == STK_POP && coreRun);
  c_wake: cover property ($rose(coreRun));
endmodule : cpu_rf_asserts

bind cpu_register_file_stack_wake cpu_rf_asserts chk_u (.*);

/* File: wake_wait_timer.sv */
// Wake-up timer: oscillator settle time then selectable state wait
`timescale 1ns/100ps
`include "cpu_regs_consts.svh"
module wake_wait_timer
  import cpu_regs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clkEn,
  input  wire logic       haltReq,
  input  wire logic       wakeIrq,
  input  wire logic       oscStable,
  input  wire logic [2:0] standbyWaitSelect,
  input  wire logic       extendedWait,
  output logic            coreRun
);
  wake_state_t                  state_q, state_d;
  logic [`WAIT_CNT_W-1:0]       cnt_q, cnt_d;
  logic [`WAIT_CNT_W-1:0]       waitLen;
  logic [`WAIT_CNT_W-1:0]       waitSafe;

  // Long variant table for codes 2..4 when extendedWait is strapped
  always_comb begin
    unique case (standbyWaitSelect)
      3'h0: waitLen = `WAIT_SEL_0;
      3'h1: waitLen = `WAIT_SEL_1;
      3'h2: waitLen = extendedWait ? `WAIT_EXT_2 : `WAIT_SEL_2;
      3'h3: waitLen = extendedWait ? `WAIT_EXT_3 : `WAIT_SEL_3;
      3'h4: waitLen = extendedWait ? `WAIT_EXT_4 : `WAIT_SEL_4;
      3'h5: waitLen = `WAIT_SEL_5;
      3'h6: waitLen = `WAIT_SEL_6;
      3'h7: waitLen = `WAIT_SEL_7;
    endcase
  end
  // External clock code (2 states) is lifted to the 8-state floor after a halt
  assign waitSafe = (waitLen < `WAIT_MIN_STATES) ? `WAIT_MIN_STATES : waitLen;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      WK_RUN:    if (haltReq) state_d = WK_HALT;
      WK_HALT:   if (wakeIrq) state_d = WK_SETTLE;
      WK_SETTLE: if (oscStable) begin
        state_d = WK_WAIT;
        cnt_d   = waitSafe - `WAIT_CNT_W'(1);
      end
      WK_WAIT: begin
        if (cnt_q == '0) state_d = WK_RUN;
        else cnt_d = cnt_q - `WAIT_CNT_W'(1);
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= WK_RUN;
      cnt_q   <= '0;
    end else if (clkEn) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign coreRun = (state_q == WK_RUN);
endmodule : wake_wait_timer
